// File: verilog/cls_link_regs.sv
`timescale 1ns/1ps
`default_nettype none

module cls_link_regs #(
   parameter logic [12:0] NORMAL_FTS = cls_pkg::NORMAL_FTS_COUNT,
   parameter logic [12:0] NORMAL_TS1 = cls_pkg::NORMAL_TS1_COUNT,
   parameter logic [5:0] MAX_LANES = cls_pkg::MAX_LANES_RST
) (
   input wire logic clk,
   input wire logic nrst,
   input wire cls_pkg::cls_req_t req,
   output logic [15:0] rdata,
   output logic rvalid,
   input wire cls_pkg::cls_link_t link,
   input wire logic l0sExitReq,
   input wire logic recoveryLockReq,
   input wire logic osSent,
   output logic sendFts,
   output logic sendSkp,
   output logic sendTs1,
   output logic l0sExitDone,
   output logic recoveryLockDone,
   output logic l0sAllowed,
   output logic l1Allowed,
   output logic extSyncActive
);

   logic extended_training_sync_q;
   logic rsvdBit_q;
   logic [1:0] aspm_q;
   logic [5:0] width_q;
   logic [5:0] width_d;
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic [15:0] ctrlView;
   logic [15:0] statView;
   cls_pkg::cls_seq_t state_q;
   logic [12:0] count_q;
   logic seqExt_q;
   logic l0sDone_q;
   logic recDone_q;
   logic l0sOk_q;
   logic l1Ok_q;
   logic sendFts_q;
   logic sendSkp_q;
   logic sendTs1_q;
   logic lastOs;

   // legal lane code that fits the advertised maximum
   function automatic logic widthOk(input logic [5:0] lanes,
                                    input logic [5:0] maxLanes);
      logic legal;
      legal = (lanes == cls_pkg::LANES_X1) || (lanes == cls_pkg::LANES_X2)
            || (lanes == cls_pkg::LANES_X4);
      widthOk = legal && (lanes <= maxLanes);
   endfunction : widthOk

   ////////////////////////////////////////////////////////////////////
   // register writes
   ////////////////////////////////////////////////////////////////////

   // only low byte holds writable bits; high byte is reserved
   always_ff @(posedge clk) begin
      if (!nrst) begin
         extended_training_sync_q <= cls_pkg::LINK_CONTROL_RST[cls_pkg::EXT_SYNC_BIT];
         rsvdBit_q <= cls_pkg::LINK_CONTROL_RST[cls_pkg::RSVD_RW_BIT];
         aspm_q <= cls_pkg::LINK_CONTROL_RST[cls_pkg::ASPM_HI:cls_pkg::ASPM_LO];
      end else if (req.wr && req.addr == cls_pkg::LINK_CONTROL_OFS
                   && req.be[0]) begin
         extended_training_sync_q <= req.wdata[cls_pkg::EXT_SYNC_BIT];
         rsvdBit_q <= req.wdata[cls_pkg::RSVD_RW_BIT];
         aspm_q <= req.wdata[cls_pkg::ASPM_HI:cls_pkg::ASPM_LO];
      end
      // writes to bits 15:8, 6:3 and link_status are dropped
   end

   // power level decode; reserved code 10 allows nothing
   always_ff @(posedge clk) begin
      if (!nrst) begin
         l0sOk_q <= 1'b0;
         l1Ok_q <= 1'b0;
      end else begin
         l0sOk_q <= (aspm_q == cls_pkg::ASPM_L0S)
                  || (aspm_q == cls_pkg::ASPM_L0S_L1);
         l1Ok_q <= (aspm_q == cls_pkg::ASPM_L0S_L1);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // negotiated width tracking
   ////////////////////////////////////////////////////////////////////

   // report width only in L0, L0s or L1 after negotiation
   always_comb begin
      width_d = cls_pkg::WIDTH_RST;
      if (link.widthDone && link.state != cls_pkg::CLS_LS_OTHER
          && widthOk(link.lanes, MAX_LANES)) begin
         width_d = link.lanes;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         width_q <= cls_pkg::WIDTH_RST;
      end else begin
         width_q <= width_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register reads
   ////////////////////////////////////////////////////////////////////

   // reserved fields except control bit 2 are zero; rate fixed at 2.5 Gb/s
   always_comb begin
      ctrlView = 16'h0000;
      ctrlView[cls_pkg::EXT_SYNC_BIT] = extended_training_sync_q;
      ctrlView[cls_pkg::RSVD_RW_BIT] = rsvdBit_q;
      ctrlView[cls_pkg::ASPM_HI:cls_pkg::ASPM_LO] = aspm_q;
      statView = 16'h0000;
      statView[cls_pkg::WIDTH_HI:cls_pkg::WIDTH_LO] = width_q;
      statView[cls_pkg::RATE_HI:0] = cls_pkg::RATE_2G5;
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req.rd;
         if (!req.rd) begin
            rdata_q <= 16'h0000;
         end else if (req.addr == cls_pkg::LINK_CONTROL_OFS) begin
            rdata_q <= ctrlView;
         end else if (req.addr == cls_pkg::LINK_STATUS_OFS) begin
            rdata_q <= statView;
         end else begin
            rdata_q <= 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // ordered-set sequencer
   ////////////////////////////////////////////////////////////////////

   assign lastOs = osSent && (count_q == 13'h0001);

   // count length chosen from extended sync at sequence start
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= cls_pkg::CLS_IDLE;
         count_q <= 13'h0000;
         seqExt_q <= 1'b0;
         l0sDone_q <= 1'b0;
         recDone_q <= 1'b0;
         sendFts_q <= 1'b0;
         sendSkp_q <= 1'b0;
         sendTs1_q <= 1'b0;
      end else begin
         l0sDone_q <= 1'b0;
         recDone_q <= 1'b0;
         case (state_q)
            cls_pkg::CLS_IDLE: begin
               seqExt_q <= extended_training_sync_q;
               if (l0sExitReq) begin
                  state_q <= cls_pkg::CLS_FTS;
                  sendFts_q <= 1'b1;
                  count_q <= extended_training_sync_q ? cls_pkg::EXT_FTS_COUNT
                                       : NORMAL_FTS;
               end else if (recoveryLockReq) begin
                  state_q <= cls_pkg::CLS_TS1;
                  sendTs1_q <= 1'b1;
                  count_q <= extended_training_sync_q ? cls_pkg::EXT_TS1_COUNT
                                       : NORMAL_TS1;
               end
            end
            cls_pkg::CLS_FTS: begin
               if (lastOs) begin
                  sendFts_q <= 1'b0;
                  if (seqExt_q) begin
                     state_q <= cls_pkg::CLS_SKP;
                     sendSkp_q <= 1'b1;
                  end else begin
                     state_q <= cls_pkg::CLS_IDLE;
                     l0sDone_q <= 1'b1;
                  end
               end else if (osSent) begin
                  count_q <= count_q - 13'h0001;
               end
            end
            cls_pkg::CLS_SKP: begin
               if (osSent) begin
                  state_q <= cls_pkg::CLS_IDLE; // single SKP
                  sendSkp_q <= 1'b0;
                  l0sDone_q <= 1'b1;
               end
            end
            cls_pkg::CLS_TS1: begin
               if (lastOs) begin
                  state_q <= cls_pkg::CLS_IDLE;
                  sendTs1_q <= 1'b0;
                  recDone_q <= 1'b1;
               end else if (osSent) begin
                  count_q <= count_q - 13'h0001;
               end
            end
            default: begin
               state_q <= cls_pkg::CLS_IDLE;
               sendFts_q <= 1'b0;
               sendSkp_q <= 1'b0;
               sendTs1_q <= 1'b0;
            end
         endcase
      end
   end

   // outputs straight from flops
   assign rdata = rdata_q;
   assign rvalid = rvalid_q;
   assign sendFts = sendFts_q;
   assign sendSkp = sendSkp_q;
   assign sendTs1 = sendTs1_q;
   assign l0sExitDone = l0sDone_q;
   assign recoveryLockDone = recDone_q;
   assign l0sAllowed = l0sOk_q;
   assign l1Allowed = l1Ok_q;
   assign extSyncActive = extended_training_sync_q;

endmodule : cls_link_regs

`default_nettype wire

// File: verilog/cls_pkg.sv
package cls_pkg;
   // register byte offsets in link register space
   localparam logic [7:0] LINK_CONTROL_OFS = 8'h88;
   localparam logic [7:0] LINK_STATUS_OFS = 8'h8a;
   // link_control fields
   localparam int EXT_SYNC_BIT = 7;
   localparam int RSVD_RW_BIT = 2;
   localparam int ASPM_LO = 0;
   localparam int ASPM_HI = 1;
   localparam logic [15:0] LINK_CONTROL_RST = 16'h0000;
   localparam logic [1:0] ASPM_OFF = 2'h0;
   localparam logic [1:0] ASPM_L0S = 2'h1;
   localparam logic [1:0] ASPM_RSVD = 2'h2;
   localparam logic [1:0] ASPM_L0S_L1 = 2'h3;
   // link_status fields
   localparam int WIDTH_LO = 4;
   localparam int WIDTH_HI = 9;
   localparam int RATE_HI = 3;
   localparam logic [3:0] RATE_2G5 = 4'h1;
   localparam logic [5:0] WIDTH_RST = 6'h00;
   localparam logic [5:0] LANES_X1 = 6'h01;
   localparam logic [5:0] LANES_X2 = 6'h02;
   localparam logic [5:0] LANES_X4 = 6'h04;
   localparam logic [5:0] MAX_LANES_RST = 6'h04;
   // ordered-set counts
   localparam int CNT_W = 13;
   localparam logic [12:0] EXT_FTS_COUNT = 13'h1000;
   localparam logic [12:0] EXT_TS1_COUNT = 13'h0400;
   localparam logic [12:0] NORMAL_FTS_COUNT = 13'h0080;
   localparam logic [12:0] NORMAL_TS1_COUNT = 13'h0010;

   // link power states reported by the link layer
   typedef enum logic [1:0] {
      CLS_LS_L0 = 2'b00,
      CLS_LS_L0S = 2'b01,
      CLS_LS_L1 = 2'b10,
      CLS_LS_OTHER = 2'b11
   } cls_lstate_t;

   // training sequencer states
   typedef enum logic [1:0] {
      CLS_IDLE = 2'b00,
      CLS_FTS = 2'b01,
      CLS_SKP = 2'b10,
      CLS_TS1 = 2'b11
   } cls_seq_t;

   // register access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
   } cls_req_t;

   // link layer status
   typedef struct packed {
      cls_lstate_t state;
      logic widthDone;
      logic [5:0] lanes;
   } cls_link_t;
endpackage : cls_pkg

// File: sim/cls_link_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cls_link_regs_properties #(
   parameter logic [5:0] MAX_LANES = 6'h04
) (
   input wire logic clk,
   input wire logic nrst,
   input wire cls_pkg::cls_req_t req,
   input wire logic [15:0] rdata,
   input wire logic rvalid,
   input wire cls_pkg::cls_link_t link,
   input wire logic l0sExitReq,
   input wire logic recoveryLockReq,
   input wire logic osSent,
   input wire logic sendFts,
   input wire logic sendSkp,
   input wire logic sendTs1,
   input wire logic l0sExitDone,
   input wire logic l0sAllowed,
   input wire logic l1Allowed
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [7:0] addrQ;
   logic stRd;
   logic ctRd;
   // address of the read being answered
   always_ff @(posedge clk) addrQ <= req.addr;
   assign stRd = rvalid && addrQ == 8'h8a;
   assign ctRd = rvalid && addrQ == 8'h88;
   a_rate_fixed: assert property (stRd |-> rdata[3:0] == 4'h1)
      else $error("rate field wrong");
   a_status_rsvd: assert property (stRd |-> rdata[15:10] == 6'h00)
      else $error("status reserved bits set");
   a_width_code: assert property (stRd |->
      rdata[9:4] inside {6'h00, 6'h01, 6'h02, 6'h04})
      else $error("width code reserved");
   a_width_max: assert property (stRd |-> rdata[9:4] <= MAX_LANES)
      else $error("width above maximum");
   a_width_unset: assert property (stRd && !$past(link.widthDone)
      && !$past(link.widthDone, 2) |-> rdata[9:4] == 6'h00)
      else $error("width shown before negotiation");
   a_ctrl_rsvd: assert property (ctRd |-> rdata[15:8] == 8'h00
      && rdata[6:3] == 4'h0) else $error("control reserved bits set");
   a_aspm_order: assert property (l1Allowed |-> l0sAllowed)
      else $error("l1 without l0s");
   a_skp_single: assert property (sendSkp && osSent |=>
      !sendSkp && l0sExitDone) else $error("skip set not single");
   a_ts1_start: assert property (recoveryLockReq && !l0sExitReq
      && !(sendFts || sendSkp || sendTs1) |=> sendTs1)
      else $error("ts1 run not started");
   c_exit: cover property (l0sExitDone);
   c_skp: cover property (sendSkp);
   c_width: cover property (stRd && rdata[9:4] != 6'h00);
endmodule : cls_link_regs_properties
bind cls_link_regs cls_link_regs_properties #(.MAX_LANES(MAX_LANES)) i_props(
   .clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
   .link(link), .l0sExitReq(l0sExitReq), .recoveryLockReq(recoveryLockReq),
   .osSent(osSent), .sendFts(sendFts), .sendSkp(sendSkp), .sendTs1(sendTs1),
   .l0sExitDone(l0sExitDone), .l0sAllowed(l0sAllowed), .l1Allowed(l1Allowed));
`default_nettype wire

// File: sim/cls_link_peer.sv
`timescale 1ns/1ps
`default_nettype none
module cls_link_peer (
   input wire logic clk,
   input wire logic slow,
   input wire logic sendFts,
   input wire logic sendSkp,
   input wire logic sendTs1,
   output logic osSent,
   output int nFts,
   output int nSkp,
   output int nTs1
);
   logic gap = 1'b0;
   initial osSent = 1'b0;
   initial nFts = 0;
   initial nSkp = 0;
   initial nTs1 = 0;
   // one set per cycle, or every other cycle when slow
   always @(negedge clk) begin
      gap <= !gap;
      osSent <= (sendFts || sendSkp || sendTs1) && !(slow && gap);
   end
   // tally the sets that went out
   always @(posedge clk) begin
      if (osSent) begin
         nFts <= nFts + int'(sendFts);
         nSkp <= nSkp + int'(sendSkp);
         nTs1 <= nTs1 + int'(sendTs1);
      end
   end
endmodule : cls_link_peer
`default_nettype wire

// File: sim/test_chipset_link_ctrl_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_chipset_link_ctrl_status;
   localparam logic [5:0] MAXL = 6'h02;
   logic clk, nrst, l0sExitReq, recoveryLockReq, slow, osSent, rvalid;
   logic sendFts, sendSkp, sendTs1, l0sExitDone, recoveryLockDone;
   logic l0sAllowed, l1Allowed, extSyncActive;
   logic [15:0] rdata;
   logic [31:0] seed = 32'h6403;
   cls_pkg::cls_req_t req;
   cls_pkg::cls_link_t link;
   int num_errors = 0, n_compared = 0, nFts, nSkp, nTs1;
   cls_link_regs #(.NORMAL_FTS(13'h0002), .NORMAL_TS1(13'h0002),
      .MAX_LANES(MAXL)) i_dut (.clk(clk), .nrst(nrst), .req(req),
      .rdata(rdata), .rvalid(rvalid), .link(link), .l0sExitReq(l0sExitReq),
      .recoveryLockReq(recoveryLockReq), .osSent(osSent), .sendFts(sendFts),
      .sendSkp(sendSkp), .sendTs1(sendTs1), .l0sExitDone(l0sExitDone),
      .recoveryLockDone(recoveryLockDone), .l0sAllowed(l0sAllowed),
      .l1Allowed(l1Allowed), .extSyncActive(extSyncActive));
   cls_link_peer i_peer (.clk(clk), .slow(slow), .sendFts(sendFts),
      .sendSkp(sendSkp), .sendTs1(sendTs1), .osSent(osSent), .nFts(nFts),
      .nSkp(nSkp), .nTs1(nTs1));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? (x >> 1) ^ 32'h8020_0003 : x >> 1;
   endfunction : lfsr
   function automatic logic [15:0] stat(input cls_pkg::cls_link_t l);
      logic ok;
      ok = l.widthDone && l.state != cls_pkg::CLS_LS_OTHER
         && l.lanes <= MAXL && l.lanes inside {6'h01, 6'h02, 6'h04};
      return {6'h00, ok ? l.lanes : 6'h00, 4'h1};
   endfunction : stat
   task automatic end_sim;
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd = 1'b0;
      chk(rvalid ? rdata : ~exp, exp);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [1:0] b,
      input logic [15:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.be = b;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
   endtask : wr
   task automatic run(input logic k, input int fts, skp, ts1);
      int f, s, t, i;
      f = nFts;
      s = nSkp;
      t = nTs1;
      l0sExitReq = k;
      recoveryLockReq = !k;
      @(negedge clk);
      l0sExitReq = 1'b0;
      recoveryLockReq = 1'b0;
      for (i = 0; i < 9000 && !(l0sExitDone || recoveryLockDone); i++)
         @(negedge clk);
      if (i >= 9000) begin
         num_errors++;
         end_sim();
      end
      chk({14'h0000, l0sExitDone, recoveryLockDone}, {14'h0000, k, !k});
      chk(16'(nFts - f), 16'(fts));
      chk(16'(nSkp - s), 16'(skp));
      chk(16'(nTs1 - t), 16'(ts1));
   endtask : run
   // free running clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // main sequence
   initial begin
      logic [15:0] ctl;
      ctl = 16'h0000;
      nrst = 1'b0;
      req = '0;
      link = '0;
      l0sExitReq = 1'b0;
      recoveryLockReq = 1'b0;
      slow = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      rd(8'h88, 16'h0000);
      @(negedge clk);
      rd(8'h8a, 16'h0001);
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         if (seed[16]) ctl = {seed[15:2], i[1:0]} & 16'h0087;
         wr(8'h88, seed[17:16], {seed[15:2], i[1:0]});
         rd(8'h88, ctl);
         chk({l1Allowed, l0sAllowed}, {ctl[1:0] == 2'h3, ctl[0]});
         chk(16'(extSyncActive), 16'(ctl[7]));
         wr(8'h8a, 2'h3, seed[31:16]);
         rd(8'h40, 16'h0000);
      end
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         link = cls_pkg::cls_link_t'({seed[1:0], seed[2] | i[0], 3'h0,
            seed[5:3]});
         repeat (2) @(negedge clk);
         rd(8'h8a, stat(link));
      end
      wr(8'h88, 2'h1, 16'h0000);
      run(1'b1, 2, 0, 0);
      run(1'b0, 0, 0, 2);
      wr(8'h88, 2'h1, 16'h0080);
      slow = 1'b1;
      run(1'b1, 4096, 1, 0);
      slow = 1'b0;
      run(1'b0, 0, 0, 1024);
      end_sim();
   end
endmodule : test_chipset_link_ctrl_status
`default_nettype wire
